// file: btc_pkg.sv
/*
  Constants shared by the time-of-day clock with alarm: register byte offsets,
  field positions, reset values and tick-divider counts.
  Assumes a 32-bit classic Wishbone slave, byte addresses, one register per word.
*/
// Functional notes
// R1 - twelve-hour time with AM/PM, tenth-second resolution
// R2 - four time registers: tenths, seconds, minutes, hours
// R3 - AM/PM flag is bit 7 of hours
// R4 - every time register reads back in BCD
// R5 - tick input 60 or 50 Hz, rate programmable
// R6 - programmable alarm raises interrupt on match
// R7 - alarm shares time addresses, control bit selects
// R8 - alarm write-only; reads always return time
// R9 - hours write halts counting at once
// R10 - counting resumes after next tenths write
// R11 - hours read freezes all four outputs
// R12 - tenths read releases frozen outputs
// R13 - count keeps running while outputs frozen
// R14 - host writes hours first, tenths last
// R15 - host follows any hours read with tenths read
// R16 - BCD carries; hours 11 to 12 toggles AM/PM
// R17 - alarm needs all four equal, flags once
// R18 - unused high bits of registers read zero
package btc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADR_TENTHS = 8'h00;
  localparam logic [7:0] ADR_SEC    = 8'h04;
  localparam logic [7:0] ADR_MIN    = 8'h08;
  localparam logic [7:0] ADR_HOURS  = 8'h0c;
  localparam logic [7:0] ADR_CTRL   = 8'h10;
  localparam logic [7:0] ADR_INT    = 8'h14;
  localparam logic [7:0] ADR_MASK   = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_ALARM_SEL = 0;  // 1: time addresses write the alarm
  localparam int CTRL_RATE50    = 1;  // 1: tick pin runs at 50 Hz
  localparam int INT_ALARM      = 0;
  localparam int STAT_RUNNING   = 0;
  localparam int STAT_FROZEN    = 1;
  localparam int HOURS_PM       = 7;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_TENTHS = 8'h00;
  localparam logic [7:0] RST_SEC    = 8'h00;
  localparam logic [7:0] RST_MIN    = 8'h00;
  localparam logic [7:0] RST_HOURS  = 8'h12;  // 12 AM
  localparam logic [7:0] RST_ALARM  = 8'h00;  // hour 00 never matches
  localparam logic [1:0] RST_CTRL   = 2'h0;
  localparam logic       RST_MASK   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // tick pin edges per tenth of a second
  localparam logic [2:0] TICKS_60HZ = 3'h6;
  localparam logic [2:0] TICKS_50HZ = 3'h5;

endpackage

// file: btc_pin_sync.sv
/*
  Three-stage synchroniser for the tick pin, with a filtered level and a
  one-cycle rising-edge pulse.
  Assumes the pin is asynchronous to i_sys_clk and slower than it.
*/
`timescale 1ns/1ns
module btc_pin_sync
  import btc_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } btc_sync_t;

  btc_sync_t st;
  btc_sync_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // s1 only feeds s2; a change counts once s2 and s3 agree
  always_comb begin
    next_st       = st;
    next_st.s1    = i_pin;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.rise  = 1'b0;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
      next_st.rise  = st.s3 & ~st.level;
    end
  end

  // registered state
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rise = st.rise;

endmodule

// file: btc_tod_clock.sv
/*
  Time-of-day clock with alarm: BCD tenths, seconds, minutes, 12-hour hours
  with AM/PM, driven by a 50/60 Hz tick pin, with read latch, stop on hours
  write, alarm interrupt and a classic Wishbone register slave.
  Assumes a single 100 MHz clock and a synchronous active-high reset.
*/
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module btc_tod_clock
  import btc_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_tick_pin,
  output logic             o_irq
);

  typedef struct packed {
    logic [7:0]  tenths;      // live count
    logic [7:0]  sec;
    logic [7:0]  min;
    logic [7:0]  hours;
    logic [7:0]  lat_tenths;  // frozen copies for multi-register reads
    logic [7:0]  lat_sec;
    logic [7:0]  lat_min;
    logic [7:0]  lat_hours;
    logic        frozen;
    logic        running;
    logic [7:0]  al_tenths;
    logic [7:0]  al_sec;
    logic [7:0]  al_min;
    logic [7:0]  al_hours;
    logic [1:0]  ctrl;
    logic        int_stat;
    logic        mask;
    logic [2:0]  tick_cnt;
    logic        ack;
    logic [31:0] rdata;
  } btc_state_t;

  btc_state_t st;
  btc_state_t next_st;
  logic       tick_rise;

  ////////////////////////////////////////////////////////////////////////////
  // tick pin crosses into the bus clock
  btc_pin_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_pin     (i_tick_pin),
    .o_rise    (tick_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // BCD helpers
  // seconds and minutes: 00..59, top bit always zero
  function automatic logic [7:0] btc_inc60(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      if (v[6:4] == 3'h5) begin
        r = 8'h00;
      end else begin
        r = {1'b0, v[6:4] + 3'h1, 4'h0};
      end
    end else begin
      r = {1'b0, v[6:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // hours: 12, 01 .. 11, with AM/PM toggling as 11 becomes 12
  function automatic logic [7:0] btc_inc_hours(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[4:0] == 5'h12) begin
      r = {v[HOURS_PM], 7'h01};
    end else if (v[4:0] == 5'h11) begin
      r = {~v[HOURS_PM], 7'h12};                                         // R16
    end else if (v[4:0] == 5'h09) begin
      r = {v[HOURS_PM], 7'h10};
    end else begin
      r = {v[HOURS_PM], 2'h0, v[4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one access taken per request, answered the next cycle
  logic       req;
  logic       wr;
  logic       rd;
  logic [7:0] wbyte;
  logic [7:0] next_tenths;
  logic [7:0] next_sec;
  logic [7:0] next_min;
  logic [7:0] next_hours;
  logic       tenth_step;
  logic [2:0] tick_limit;
  logic       alarm_hit;

  assign req   = i_wb_cyc & i_wb_stb & ~st.ack;
  assign wr    = req & i_wb_we & i_wb_sel[0];
  assign rd    = req & ~i_wb_we;
  assign wbyte = i_wb_dat[7:0];

  // divider picks 5 or 6 pin edges per tenth
  assign tick_limit = st.ctrl[CTRL_RATE50] ? TICKS_50HZ : TICKS_60HZ;     // R5
  assign tenth_step = st.running & tick_rise & (st.tick_cnt == tick_limit - 3'h1);

  // alarm compares the new time, so it fires once on the matching step
  assign alarm_hit = tenth_step &
                     ({next_tenths, next_sec, next_min, next_hours} ==
                      {st.al_tenths, st.al_sec, st.al_min, st.al_hours});

  ////////////////////////////////////////////////////////////////////////////
  // carry chain, evaluated every cycle, applied on a tenth step
  always_comb begin
    next_tenths = st.tenths;
    next_sec    = st.sec;
    next_min    = st.min;
    next_hours  = st.hours;
    if (st.tenths[3:0] == 4'h9) begin
      next_tenths = 8'h00;                                               // R16
      next_sec    = btc_inc60(st.sec);
      if (st.sec == 8'h59) begin
        next_min = btc_inc60(st.min);
        if (st.min == 8'h59) begin
          next_hours = btc_inc_hours(st.hours);                          // R1
        end
      end
    end else begin
      next_tenths = {4'h0, st.tenths[3:0] + 4'h1};                       // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_st       = st;
    next_st.ack   = req;
    next_st.rdata = st.rdata;

    // tick divider: restarts while halted so a restart begins a full tenth
    if (!st.running) begin
      next_st.tick_cnt = 3'h0;
    end else if (tick_rise) begin
      next_st.tick_cnt = tenth_step ? 3'h0 : st.tick_cnt + 3'h1;
    end

    // live count advances even while outputs are frozen
    if (tenth_step) begin
      next_st.tenths = next_tenths;                                      // R13
      next_st.sec    = next_sec;
      next_st.min    = next_min;
      next_st.hours  = next_hours;
      // a match sets the flag; the clearing read below keeps it set
      if (alarm_hit) begin
        next_st.int_stat = 1'b1;                                         // R17
      end
    end

    // register reads: time addresses always show time, never the alarm
    if (rd) begin
      case (i_wb_adr)
        ADR_TENTHS: begin
          next_st.rdata  = {24'h0, st.frozen ? st.lat_tenths : st.tenths}; // R8
          next_st.frozen = 1'b0;                                         // R12
        end
        ADR_SEC: begin
          next_st.rdata = {24'h0, st.frozen ? st.lat_sec : st.sec};      // R4
        end
        ADR_MIN: begin
          next_st.rdata = {24'h0, st.frozen ? st.lat_min : st.min};      // R2
        end
        ADR_HOURS: begin
          next_st.rdata = {24'h0, st.frozen ? st.lat_hours : st.hours};  // R3
          if (!st.frozen) begin
            next_st.frozen     = 1'b1;                                   // R11
            next_st.lat_tenths = st.tenths;
            next_st.lat_sec    = st.sec;
            next_st.lat_min    = st.min;
            next_st.lat_hours  = st.hours;
          end
        end
        ADR_CTRL: begin
          next_st.rdata = {30'h0, st.ctrl};
        end
        ADR_INT: begin
          next_st.rdata = {31'h0, st.int_stat};
          // read clears, but an alarm in this very cycle wins
          next_st.int_stat = alarm_hit;
        end
        ADR_MASK: begin
          next_st.rdata = {31'h0, st.mask};
        end
        ADR_STATUS: begin
          next_st.rdata = {30'h0, st.frozen, st.running};
        end
        default: begin
          next_st.rdata = 32'h0;
        end
      endcase
    end

    // register writes: alarm-select bit steers time addresses
    if (wr) begin
      case (i_wb_adr)
        ADR_TENTHS: begin
          if (st.ctrl[CTRL_ALARM_SEL]) begin
            next_st.al_tenths = {4'h0, wbyte[3:0]};                      // R7
          end else begin
            next_st.tenths  = {4'h0, wbyte[3:0]};
            next_st.running = 1'b1;                                      // R10
          end
        end
        ADR_SEC: begin
          if (st.ctrl[CTRL_ALARM_SEL]) begin
            next_st.al_sec = {1'b0, wbyte[6:0]};
          end else begin
            next_st.sec = {1'b0, wbyte[6:0]};
          end
        end
        ADR_MIN: begin
          if (st.ctrl[CTRL_ALARM_SEL]) begin
            next_st.al_min = {1'b0, wbyte[6:0]};
          end else begin
            next_st.min = {1'b0, wbyte[6:0]};
          end
        end
        ADR_HOURS: begin
          if (st.ctrl[CTRL_ALARM_SEL]) begin
            next_st.al_hours = {wbyte[HOURS_PM], 2'h0, wbyte[4:0]};      // R6
          end else begin
            next_st.hours   = {wbyte[HOURS_PM], 2'h0, wbyte[4:0]};
            next_st.running = 1'b0;                                      // R9
          end
        end
        ADR_CTRL: begin
          next_st.ctrl = wbyte[1:0];
        end
        ADR_MASK: begin
          next_st.mask = wbyte[INT_ALARM];
        end
        default: begin
          next_st.rdata = st.rdata;  // unmapped or read-only: acked, ignored
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st            <= '0;
      st.tenths     <= RST_TENTHS;
      st.sec        <= RST_SEC;
      st.min        <= RST_MIN;
      st.hours      <= RST_HOURS;
      st.al_tenths  <= RST_ALARM;
      st.al_sec     <= RST_ALARM;
      st.al_min     <= RST_ALARM;
      st.al_hours   <= RST_ALARM;
      st.ctrl       <= RST_CTRL;
      st.mask       <= RST_MASK;
      st.running    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign o_wb_ack = st.ack;
  assign o_wb_dat = st.rdata;
  assign o_irq    = st.int_stat & st.mask;                               // R6

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  function automatic logic hit(input logic [7:0] a);
    return i_wb_cyc & i_wb_stb & ~o_wb_ack & (i_wb_adr == a);
  endfunction

  sequence s_hours_write;
    hit(ADR_HOURS) & i_wb_we & i_wb_sel[0] & ~st.ctrl[CTRL_ALARM_SEL];
  endsequence

  sequence s_tenths_write;
    hit(ADR_TENTHS) & i_wb_we & i_wb_sel[0] & ~st.ctrl[CTRL_ALARM_SEL];
  endsequence

  sequence s_int_read;
    hit(ADR_INT) & ~i_wb_we;
  endsequence

  a_ack_one_cycle:    assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held more than one cycle");
  a_hours_stop:       assert property (s_hours_write |=> !st.running)    // R9
    else $error("hours write did not halt counting");
  a_tenths_start:     assert property (s_tenths_write |=> st.running)    // R10
    else $error("tenths write did not restart counting");
  a_halt_holds_time:  assert property (!st.running && !$past(wr) |=>
                                       $stable(st.tenths) || $past(wr))
    else $error("time advanced while halted");
  a_hours_read_latch: assert property (hit(ADR_HOURS) & ~i_wb_we |=>
                                       st.frozen ##1 (st.frozen || $past(rd)))  // R11
    else $error("hours read did not freeze outputs");
  a_tenths_release:   assert property (hit(ADR_TENTHS) & ~i_wb_we |=> !st.frozen) // R12
    else $error("tenths read did not release freeze");
  a_count_while_frozen: assert property (st.frozen && tenth_step && !wr |=>
                                         st.tenths != $past(st.tenths))  // R13
    else $error("count stalled while frozen");
  a_irq_level_gate:   assert property ($rose(o_irq) |-> $past(alarm_hit) || $past(wr)) // R6
    else $error("irq rose without an alarm or a mask write");
  a_bcd_digits:       assert property (st.tenths[7:4] == 4'h0 && st.tenths[3:0] <= 4'h9
                                       && st.sec[7] == 1'b0)             // R18
    else $error("time register left BCD range");
  a_pm_toggle:        assert property (tenth_step && st.hours[4:0] == 5'h11 &&
                                       st.min == 8'h59 && st.sec == 8'h59 &&
                                       st.tenths == 8'h09 && !wr |=>
                                       st.hours[HOURS_PM] != $past(st.hours[HOURS_PM])) // R16
    else $error("AM/PM flag did not toggle at 11 to 12");
  // alarm flag: a match sets it and wins over a clearing read in the same cycle
  a_alarm_sets:       assert property (alarm_hit |=> st.int_stat)        // R17
    else $error("alarm match did not set the flag");
  a_int_read_clear:   assert property (s_int_read ##0 !alarm_hit |=> !st.int_stat) // R17
    else $error("status read did not clear the alarm flag");
  // reads of time addresses return time, the frozen copy while frozen
  a_read_live_time:   assert property (rd && i_wb_adr == ADR_SEC && !st.frozen |=>
                                       o_wb_dat == {24'h0, $past(st.sec)}) // R8
    else $error("seconds read did not return the live time");
  a_read_frozen_min:  assert property (rd && i_wb_adr == ADR_MIN && st.frozen |=>
                                       o_wb_dat == {24'h0, $past(st.lat_min)}) // R11
    else $error("minutes read did not return the frozen copy");

endmodule

// file: btc_host_model.sv
/*
  Host model for the time-of-day clock: a classic Wishbone master that runs
  one single cycle at a time and waits for the slave's ack.
  Assumes one clock shared with the slave; the bench calls its tasks.
*/
`timescale 1ns/1ns
module btc_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic        i_wb_ack,
  output logic             o_wb_cyc,
  output logic             o_wb_stb,
  output logic             o_wb_we,
  output logic [7:0]       o_wb_adr,
  output logic [31:0]      o_wb_dat,
  output logic [3:0]       o_wb_sel
);
  ////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    o_wb_cyc = 1'b0;
    o_wb_stb = 1'b0;
    o_wb_we  = 1'b0;
    o_wb_adr = 8'h00;
    o_wb_dat = 32'h0;
    o_wb_sel = 4'h0;
  end

  // one request held until ack is sampled; release leaves a gap cycle because
  // the next call waits for an edge before raising the strobe again
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel, output logic [31:0] rdat);
    @(posedge i_sys_clk);
    o_wb_cyc <= 1'b1;
    o_wb_stb <= 1'b1;
    o_wb_we  <= we;
    o_wb_adr <= adr;
    o_wb_dat <= dat;
    o_wb_sel <= sel;
    @(posedge i_sys_clk);
    while (i_wb_ack !== 1'b1) @(posedge i_sys_clk);
    rdat = i_wb_dat;
    o_wb_cyc <= 1'b0;
    o_wb_stb <= 1'b0;
    o_wb_dat <= ~dat;  // stale data is not left on the bus
  endtask

  // full time read: hours first latches, tenths last releases the latch
  task automatic read_all(output logic [31:0] h, output logic [31:0] m,
                          output logic [31:0] s, output logic [31:0] t);
    wb_cycle(1'b0, 8'h0c, 32'h0, 4'hf, h);
    wb_cycle(1'b0, 8'h08, 32'h0, 4'hf, m);
    wb_cycle(1'b0, 8'h04, 32'h0, 4'hf, s);
    wb_cycle(1'b0, 8'h00, 32'h0, 4'hf, t);
  endtask
endmodule

// file: bcd_time_of_day_clock_alarm_test.sv
/*
  Self-checking bench for the time-of-day clock with alarm.
  Assumes the host model for bus cycles and drives a fast tick pin itself.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module bcd_time_of_day_clock_alarm_test;
  import btc_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_reset   = 1'b1;
  logic        tick_pin  = 1'b0;
  logic        cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, h, m, s, t;
  logic [3:0]  sel;
  int          num_errors = 0;
  int          compares   = 0;
  int          cycles     = 0;
  // reset view, in read order: the hours read latches, the tenths read frees
  localparam logic [7:0]  ROW_ADR [10] = '{8'h04, 8'h08, 8'h0c, 8'h1c, 8'h00, 8'h1c, 8'h10, 8'h18, 8'h14, 8'h20};
  localparam logic [31:0] ROW_EXP [10] = '{32'h0, 32'h0, 32'h12, 32'h3, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0,
                                           32'h0};

  always #5 i_sys_clk = ~i_sys_clk;

  btc_host_model host (
    .i_sys_clk (i_sys_clk), .i_wb_dat (rdat), .i_wb_ack (ack), .o_wb_cyc (cyc), .o_wb_stb (stb),
    .o_wb_we (we), .o_wb_adr (adr), .o_wb_dat (wdat), .o_wb_sel (sel));

  btc_tod_clock uut (
    .i_sys_clk (i_sys_clk), .i_reset (i_reset), .i_wb_cyc (cyc), .i_wb_stb (stb), .i_wb_we (we),
    .i_wb_adr (adr), .i_wb_dat (wdat), .i_wb_sel (sel), .o_wb_dat (rdat), .o_wb_ack (ack),
    .i_tick_pin (tick_pin), .o_irq (irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // a hang is cut short long after the expected run of under a thousand cycles
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] junk;
    host.wb_cycle(1'b1, a, {24'h0, d}, 4'h1, junk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] got;
    host.wb_cycle(1'b0, a, 32'h0, 4'hf, got);
    `CHK($sformatf("reg %h", a), ex, got)
  endtask

  // pin rises spaced far beyond the synchroniser; a pause lets the last land
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      tick_pin <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      tick_pin <= 1'b0;
      repeat (8) @(posedge i_sys_clk);
    end
    repeat (10) @(posedge i_sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    // reset values, latch set by hours and freed by tenths, unmapped reads zero
    for (int i = 0; i < 10; i++) rdc(ROW_ADR[i], ROW_EXP[i]);
    // set 11:59:59.9 AM, hours first and tenths last
    wr(ADR_HOURS, 8'h11);
    ticks(8);
    rdc(ADR_STATUS, 32'h0);
    wr(ADR_MIN, 8'h59);
    wr(ADR_SEC, 8'h59);
    rdc(ADR_STATUS, 32'h0);
    wr(ADR_TENTHS, 8'h09);
    rdc(ADR_STATUS, 32'h1);
    // six rises at 60 Hz roll every digit and flip to PM
    ticks(6);
    host.read_all(h, m, s, t);
    `CHK("hours", 32'h92, h)
    `CHK("min", 32'h0, m)
    `CHK("sec", 32'h0, s)
    `CHK("tenths", 32'h0, t)
    // latched outputs hold while the count keeps running
    rdc(ADR_HOURS, 32'h92);
    ticks(6);
    rdc(ADR_STATUS, 32'h3);
    rdc(ADR_TENTHS, 32'h0);
    rdc(ADR_TENTHS, 32'h1);
    // 50 Hz: five rises make one tenth
    wr(ADR_CTRL, 8'h02);
    ticks(5);
    rdc(ADR_TENTHS, 32'h2);
    // alarm at 12:00:00.3 PM through the shared addresses
    wr(ADR_CTRL, 8'h03);
    wr(ADR_HOURS, 8'h92);
    wr(ADR_MIN, 8'h00);
    wr(ADR_SEC, 8'h00);
    wr(ADR_TENTHS, 8'h03);
    rdc(ADR_STATUS, 32'h1);
    rdc(ADR_TENTHS, 32'h2);
    rdc(ADR_HOURS, 32'h92);
    rdc(ADR_TENTHS, 32'h2);
    wr(ADR_CTRL, 8'h02);
    // byte lane 0 off: the mask write is ignored
    host.wb_cycle(1'b1, ADR_MASK, 32'h1, 4'h0, s);
    ticks(5);
    rdc(ADR_TENTHS, 32'h3);
    `CHK("irq masked", 1'b0, irq)
    wr(ADR_MASK, 8'h01);
    repeat (2) @(posedge i_sys_clk);
    `CHK("irq raised", 1'b1, irq)
    rdc(ADR_INT, 32'h1);
    repeat (2) @(posedge i_sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    rdc(ADR_INT, 32'h0);
    // flagged once: the following step no longer matches
    ticks(5);
    rdc(ADR_INT, 32'h0);
    // reset in mid-run: rate, mask, time and latch return to reset values
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    repeat (16) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rdc(ADR_CTRL, 32'h0);
    rdc(ADR_MASK, 32'h0);
    rdc(ADR_HOURS, 32'h12);
    rdc(ADR_STATUS, 32'h3);
    rdc(ADR_TENTHS, 32'h0);
    final_report();
  end
endmodule
